// >>> rtl/dma_channels.v
// Four-channel DMA controller: register bank on AHB-Lite and the transfer engine.
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`include "dma_map.vh"
module dma_channels
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [127:0] peripheral_request_lines,
  input wire [15:0] ram_rdata,
  input wire [15:0] per_rdata,
  input wire ram_wr_clash,
  input wire per_wr_clash,
  output reg [15:0] ram_addr_q,
  output reg ram_rd_q,
  output reg ram_wr_q,
  output reg ram_byte_q,
  output reg [15:0] per_addr_q,
  output reg per_rd_q,
  output reg per_wr_q,
  output reg [15:0] xfer_wdata_q,
  output reg [3:0] block_event_q
);
  // --------------------------------------------------------------------------
  // Bus front end.
  // --------------------------------------------------------------------------
  reg wr_q;
  reg rd_q;
  reg [7:0] waddr_q;
  reg [7:0] raddr_q;
  reg [31:0] rd_mux;
  wire take = hsel & hready & htrans[1];
  wire [3:0] chsel = waddr_q[7] ? 4'h0 : (4'h1 << waddr_q[6:5]);
  wire [15:0] wd = hwdata[15:0];
  // Engine state seen by the channels.
  reg [1:0] state_q;
  reg [1:0] ch_q;
  reg [15:0] data_q;
  reg [3:0] lastch_q;
  reg [15:0] last_addr_q;
  reg [3:0] pcol_q;
  reg [3:0] xcol_q;
  wire [3:0] fin;
  wire [3:0] gnt;
  wire [63:0] con_v;
  wire [63:0] req_v;
  wire [63:0] sta_v;
  wire [63:0] stb_v;
  wire [63:0] pad_v;
  wire [39:0] cnt_v;
  wire [63:0] ptr_v;
  wire [3:0] ready_v;
  wire [3:0] pingpong_select_status_v;
  wire [3:0] hit_v;

  // Writes land at the end of the data phase, reads take one wait state so
  // that a read right after a write returns the freshly written value.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      waddr_q <= 8'h00;
      raddr_q <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
      wr_q <= take & hwrite;
      if (take)
      begin
        waddr_q <= haddr[7:0];
        raddr_q <= haddr[7:0];
      end
      if (take & ~hwrite)
      begin
        rd_q <= 1'b1;
        hreadyout <= 1'b0;
      end
      else if (rd_q)
      begin
        rd_q <= 1'b0;
        hrdata <= rd_mux;
        hreadyout <= 1'b1;
      end
    end
  end

  // Read decode; unmapped offsets and unimplemented bits read zero.
  always @*
  begin
    rd_mux = 32'h00000000;
    if (!raddr_q[7])
    begin
      case (raddr_q[4:2])
        `OFF_CONTROL: rd_mux[15:0] = con_v[16*raddr_q[6:5] +: 16];
        `OFF_REQ_SEL: rd_mux[15:0] = req_v[16*raddr_q[6:5] +: 16];
        `OFF_PRIMARY: rd_mux[15:0] = sta_v[16*raddr_q[6:5] +: 16];
        `OFF_SECONDARY: rd_mux[15:0] = stb_v[16*raddr_q[6:5] +: 16];
        `OFF_PERIPH: rd_mux[15:0] = pad_v[16*raddr_q[6:5] +: 16];
        `OFF_COUNT: rd_mux[9:0] = cnt_v[10*raddr_q[6:5] +: 10];
        default: rd_mux = 32'h00000000;
      endcase
    end
    else
    begin
      case (raddr_q)
        `OFF_COLLISION: rd_mux[11:0] = {pcol_q, 4'h0, xcol_q};
        `OFF_CH_STATUS: rd_mux[11:0] = {lastch_q, 4'h0, pingpong_select_status_v};
        `OFF_LAST_ADDR: rd_mux[15:0] = last_addr_q;
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Per-channel registers and block sequencing.
  // --------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : ch
      reg [15:0] con_q;
      reg force_q;
      reg [6:0] sel_q;
      reg [15:0] sta_q;
      reg [15:0] stb_q;
      reg [15:0] pad_q;
      reg [9:0] cnt_q;
      reg [9:0] idx_q;
      reg pingpong_select_status_q;
      reg pend_q;
      reg line_q;
      wire wr_con = wr_q & chsel[i] & (waddr_q[4:2] == `OFF_CONTROL);
      wire wr_req = wr_q & chsel[i] & (waddr_q[4:2] == `OFF_REQ_SEL);
      wire line = peripheral_request_lines[sel_q];
      wire last = (idx_q == cnt_q);
      wire [15:0] base = pingpong_select_status_q ? stb_q : sta_q;
      wire [15:0] step = con_q[`CON_SIZE] ? {6'h00, idx_q} : {5'h00, idx_q, 1'b0};
      wire postinc = (con_q[5:4] == `ADDRESSING_KIND_POSTINC);
      assign con_v[16*i +: 16] = con_q;
      assign req_v[16*i +: 16] = {force_q, 8'h00, sel_q};
      assign sta_v[16*i +: 16] = sta_q;
      assign stb_v[16*i +: 16] = stb_q;
      assign pad_v[16*i +: 16] = pad_q;
      assign cnt_v[10*i +: 10] = cnt_q;
      assign pingpong_select_status_v[i] = pingpong_select_status_q;
      assign ptr_v[16*i +: 16] = postinc ? base + step : base;
      assign ready_v[i] = con_q[`CON_ON] & (pend_q | force_q);
      assign hit_v[i] = con_q[`CON_HALF] ? (idx_q == {1'b0, cnt_q[9:1]}) : last;

      // Software fields; the engine clears the enable after a one-shot block, in ping-pong mode only after the secondary buffer's block.
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          con_q <= `REG_RESET;
          force_q <= 1'b0;
          sel_q <= `REQ_SEL_RESET;
          sta_q <= `REG_RESET;
          stb_q <= `REG_RESET;
          pad_q <= `REG_RESET;
          cnt_q <= 10'h000;
        end
        else
        begin
          if (wr_con)
            con_q <= wd & `CON_WMASK;
          else if (fin[i] & last & con_q[0] & (~con_q[1] | pingpong_select_status_q))
            con_q[`CON_ON] <= 1'b0;
          if (wr_req)
            sel_q <= wd[6:0];
          // A written zero never clears force; completion does.
          if (wr_req & wd[`REQ_FORCE])
            force_q <= 1'b1;
          else if (fin[i])
            force_q <= 1'b0;
          if (wr_q & chsel[i] & (waddr_q[4:2] == `OFF_PRIMARY))
            sta_q <= wd;
          if (wr_q & chsel[i] & (waddr_q[4:2] == `OFF_SECONDARY))
            stb_q <= wd;
          if (wr_q & chsel[i] & (waddr_q[4:2] == `OFF_PERIPH))
            pad_q <= wd;
          if (wr_q & chsel[i] & (waddr_q[4:2] == `OFF_COUNT))
            cnt_q <= wd[`CNT_MSB:0];
        end
      end

      // Request edge capture, block position and buffer alternation.
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          idx_q <= 10'h000;
          pingpong_select_status_q <= 1'b0;
          pend_q <= 1'b0;
          line_q <= 1'b0;
        end
        else
        begin
          line_q <= line;
          if (line & ~line_q & con_q[`CON_ON] & ~force_q)
            pend_q <= 1'b1;
          else if (gnt[i])
            pend_q <= 1'b0;
          if (wr_con & ~wd[`CON_ON])
          begin
            idx_q <= 10'h000;
            pingpong_select_status_q <= 1'b0;
          end
          else if (fin[i])
          begin
            if (last)
            begin
              idx_q <= 10'h000;
              if (con_q[1])
                pingpong_select_status_q <= ~pingpong_select_status_q;
            end
            else
              idx_q <= idx_q + 10'h001;
          end
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Transfer engine: one transfer at a time, lowest channel first.
  // --------------------------------------------------------------------------
  wire [1:0] pick = ready_v[0] ? 2'h0 : ready_v[1] ? 2'h1 : ready_v[2] ? 2'h2 : 2'h3;
  wire start = (state_q == `ST_IDLE) & (|ready_v);
  wire [15:0] pcon = con_v[16*pick +: 16];
  wire [15:0] acon = con_v[16*ch_q +: 16];
  assign gnt = start ? (4'h1 << pick) : 4'h0;
  assign fin = (state_q == `ST_WRITE) ? (4'h1 << ch_q) : 4'h0;

  // A transfer is a read cycle then a write cycle; the source answers in the
  // cycle its read strobe stands, so no wait handshake is supported.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= `ST_IDLE;
      ch_q <= 2'h0;
      data_q <= 16'h0000;
      ram_addr_q <= 16'h0000;
      ram_rd_q <= 1'b0;
      ram_wr_q <= 1'b0;
      ram_byte_q <= 1'b0;
      per_addr_q <= 16'h0000;
      per_rd_q <= 1'b0;
      per_wr_q <= 1'b0;
      xfer_wdata_q <= 16'h0000;
      block_event_q <= 4'h0;
      last_addr_q <= 16'h0000;
      lastch_q <= `LAST_ACTIVE_CHANNEL_RESET;
    end
    else
    begin
      block_event_q <= 4'h0;
      case (state_q)
        `ST_IDLE:
        begin
          if (start)
          begin
            state_q <= `ST_READ;
            ch_q <= pick;
            ram_addr_q <= ptr_v[16*pick +: 16];
            last_addr_q <= ptr_v[16*pick +: 16];
            per_addr_q <= pad_v[16*pick +: 16];
            ram_byte_q <= pcon[`CON_SIZE];
            ram_rd_q <= pcon[`CON_DIR];
            per_rd_q <= ~pcon[`CON_DIR];
          end
        end
        `ST_READ:
        begin
          state_q <= `ST_WRITE;
          ram_rd_q <= 1'b0;
          per_rd_q <= 1'b0;
          data_q <= acon[`CON_DIR] ? ram_rdata : per_rdata;
          xfer_wdata_q <= acon[`CON_DIR] ? ram_rdata : per_rdata;
          ram_wr_q <= ~acon[`CON_DIR];
          // Null write: the peripheral also sees a write, and both it and the ram get a zero word.
          per_wr_q <= acon[`CON_DIR] | acon[`CON_NULL_PERIPHERAL_WRITE];
          if (~acon[`CON_DIR] & acon[`CON_NULL_PERIPHERAL_WRITE])
            xfer_wdata_q <= 16'h0000;
        end
        `ST_WRITE:
        begin
          state_q <= `ST_IDLE;
          ram_wr_q <= 1'b0;
          per_wr_q <= 1'b0;
          lastch_q <= {2'h0, ch_q};
          block_event_q <= fin & hit_v;
        end
        default:
          state_q <= `ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Collision flags: a clash in the write cycle wins over a same-cycle clear.
  // --------------------------------------------------------------------------
  wire clr_col = wr_q & (waddr_q == `OFF_COLLISION);
  wire [3:0] set_p = (per_wr_clash & per_wr_q) ? fin : 4'h0;
  wire [3:0] set_x = (ram_wr_clash & ram_wr_q) ? fin : 4'h0;

  // Software clears a flag by writing a one to it.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pcol_q <= 4'h0;
      xcol_q <= 4'h0;
    end
    else
    begin
      pcol_q <= set_p | (pcol_q & ~(clr_col ? wd[11:8] : 4'h0));
      xcol_q <= set_x | (xcol_q & ~(clr_col ? wd[3:0] : 4'h0));
    end
  end
endmodule // dma_channels

// >>> rtl/dma_map.vh
// Register map, field positions, reset values and codes of the four-channel DMA block.
`ifndef DMA_MAP_VH
`define DMA_MAP_VH
// ----------------------------------------------------------------------------
// Register offsets: word indices within a channel, byte offsets for the shared ones; channel n sits at n times the stride.
// ----------------------------------------------------------------------------
`define CH_STRIDE 8'h20
`define OFF_CONTROL 3'h0
`define OFF_REQ_SEL 3'h1
`define OFF_PRIMARY 3'h2
`define OFF_SECONDARY 3'h3
`define OFF_PERIPH 3'h4
`define OFF_COUNT 3'h5
`define OFF_COLLISION 8'h80
`define OFF_CH_STATUS 8'h84
`define OFF_LAST_ADDR 8'h88
// ----------------------------------------------------------------------------
// Control register fields.
// ----------------------------------------------------------------------------
`define CON_ON 15
`define CON_SIZE 14
`define CON_DIR 13
`define CON_HALF 12
`define CON_NULL_PERIPHERAL_WRITE 11
`define CON_WMASK 16'hf833
`define ADDRESSING_KIND_POSTINC 2'h0
// ----------------------------------------------------------------------------
// Request select, count and status fields.
// ----------------------------------------------------------------------------
`define REQ_FORCE 15
`define REQ_SEL_RESET 7'h7f
`define CNT_MSB 9
`define COL_PER_LSB 8
`define LAST_ACTIVE_CHANNEL_LSB 8
`define LAST_ACTIVE_CHANNEL_RESET 4'hf
`define REG_RESET 16'h0000
// ----------------------------------------------------------------------------
// Engine states.
// ----------------------------------------------------------------------------
`define ST_IDLE 2'h0
`define ST_READ 2'h1
`define ST_WRITE 2'h2
`endif

// >>> testbench/dma_channels_sva.sv
// Checker with bus and transfer engine assertions for the DMA channel block.
module dma_channels_chk
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire ram_rd_q,
  input wire ram_wr_q,
  input wire per_rd_q,
  input wire per_wr_q,
  input wire [15:0] ram_addr_q,
  input wire [15:0] per_addr_q,
  input wire [3:0] block_event_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------------------
  // Properties.
  // --------------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (!hresp)
    else $error("bus response not okay");
  read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=>
    !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  write_nowait_a: assert property (hsel && hready && htrans[1] && hwrite |=>
    hreadyout) else $error("write stalled");
  one_source_a: assert property (!(ram_rd_q && per_rd_q))
    else $error("two read strobes");
  ram_to_per_a: assert property (ram_rd_q |=> per_wr_q && !ram_wr_q)
    else $error("ram read not followed by peripheral write");
  per_to_ram_a: assert property (per_rd_q |=> ram_wr_q)
    else $error("peripheral read not followed by ram write");
  addr_hold_a: assert property (ram_rd_q || per_rd_q |=>
    $stable(ram_addr_q) && $stable(per_addr_q)) else $error("address moved");
  xfer_gap_a: assert property (ram_wr_q || per_wr_q |=> !(ram_rd_q || per_rd_q))
    else $error("transfer too short");
  block_event_a: assert property (block_event_q != 4'h0 |->
    $onehot(block_event_q) && $past(ram_wr_q || per_wr_q)) else $error("stray event");
endmodule // dma_channels_chk

bind dma_channels dma_channels_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .ram_rd_q(ram_rd_q), .ram_wr_q(ram_wr_q), .per_rd_q(per_rd_q), .per_wr_q(per_wr_q),
  .ram_addr_q(ram_addr_q), .per_addr_q(per_addr_q), .block_event_q(block_event_q));

// >>> testbench/dma_channels_tb_top.sv
// Self-checking testbench for the DMA channel block.
`include "dma_map.vh"
module dma_channels_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, clash_ram = 0, clash_per = 0, rd_ph = 0;
  logic [31:0] haddr = 0, hwdata = 0, pb, pa;
  logic [1:0] htrans = 0;
  logic [127:0] lines = 0;
  logic [3:0] ev = 0;
  wire [31:0] hrdata;
  wire [15:0] ram_rdata, per_rdata, ram_addr_q, per_addr_q, xfer_wdata_q;
  wire [3:0] block_event_q;
  wire hreadyout, hresp, ram_wr_clash, per_wr_clash, ram_rd_q, ram_wr_q, ram_byte_q;
  wire per_rd_q, per_wr_q;
  logic [15:0] exp_rd[$];
  logic [31:0] exp_wr[$];
  int n_errors = 0, tests_run = 0;
  initial forever #50 hclk = ~hclk;
  dma_channels i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .peripheral_request_lines(lines),
    .ram_rdata(ram_rdata), .per_rdata(per_rdata), .ram_wr_clash(ram_wr_clash),
    .per_wr_clash(per_wr_clash), .ram_addr_q(ram_addr_q), .ram_rd_q(ram_rd_q),
    .ram_wr_q(ram_wr_q), .ram_byte_q(ram_byte_q), .per_addr_q(per_addr_q),
    .per_rd_q(per_rd_q), .per_wr_q(per_wr_q), .xfer_wdata_q(xfer_wdata_q),
    .block_event_q(block_event_q));
  dma_far_side i_far (.hclk(hclk), .ram_addr_q(ram_addr_q), .ram_rd_q(ram_rd_q),
    .ram_wr_q(ram_wr_q), .per_addr_q(per_addr_q), .per_rd_q(per_rd_q), .per_wr_q(per_wr_q),
    .clash_ram(clash_ram), .clash_per(clash_per), .ram_rdata(ram_rdata),
    .per_rdata(per_rdata), .ram_wr_clash(ram_wr_clash), .per_wr_clash(per_wr_clash));
  // --------------------------------------------------------------------------
  // Checking and bus tasks.
  // --------------------------------------------------------------------------
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  // Bounded wait for the slave; a hang ends the run as a mismatch.
  task wait_rdy;
    for (int n = 0; !hreadyout; n++)
    begin
      if (n == 20) begin n_errors++; finish_test(); end
      @(posedge hclk);
    end
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge hclk);
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 0;
    hwdata <= d;
    @(posedge hclk);
    wait_rdy();
  endtask
  function automatic logic [7:0] adr(input int ch, input logic [2:0] off);
    adr = 8'(ch) * `CH_STRIDE + {3'h0, off, 2'h0};
  endfunction
  task rd(input logic [7:0] a, input logic [15:0] e);
    exp_rd.push_back(e);
    bus(0, a, 32'h0);
  endtask
  // Waits until the noted ram writes, or a peripheral write, have been seen.
  task wait_done(input logic per);
    for (int n = 0; per ? !per_wr_q : exp_wr.size() != 0; n++)
    begin
      if (n == 60) begin n_errors++; finish_test(); end
      @(posedge hclk);
    end
    repeat (2) @(posedge hclk);
  endtask
  // Watcher: the oldest note is compared whenever a result shows.
  always @(posedge hclk)
  begin
    if (rd_ph && hreadyout) begin chk("hrdata", {16'h0, exp_rd.pop_front()}, hrdata); rd_ph <= 0; end
    if (hsel && hreadyout && htrans[1] && !hwrite) rd_ph <= 1;
    if (ram_wr_q) chk("ram write", exp_wr.pop_front(), {ram_addr_q, xfer_wdata_q});
    // Block events are one-cycle pulses, so they are gathered as they appear.
    ev <= ev | block_event_q;
  end
  // --------------------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h0f32f1a5));
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    for (int c = 0; c < 4; c++)
    begin
      rd(adr(c, `OFF_REQ_SEL), {9'h0, `REQ_SEL_RESET});
      for (int o = 2; o < 6; o++) rd(adr(c, 3'(o)), `REG_RESET);
    end
    rd(`OFF_COLLISION, 16'h0);
    rd(`OFF_CH_STATUS, 16'h0f00);
    rd(`OFF_LAST_ADDR, 16'h0);
    rd(8'h18, 16'h0);
    for (int c = 0; c < 4; c++)
    begin
      for (int o = 2; o < 5; o++) begin pb = $urandom; bus(1, adr(c, 3'(o)), pb); rd(adr(c, 3'(o)), pb[15:0]); end
      bus(1, adr(c, `OFF_COUNT), 32'hffffffff);
      rd(adr(c, `OFF_COUNT), 16'h03ff);
      // Force stays clear here: software could not clear it again later.
      bus(1, adr(c, `OFF_REQ_SEL), 32'hffff7fff);
      rd(adr(c, `OFF_REQ_SEL), 16'h007f);
    end
    // Channel 1: forced single word into ram; addresses set while off.
    pb = $urandom;
    pa = $urandom;
    bus(1, adr(1, 2), pb);
    bus(1, adr(1, 4), pa);
    bus(1, adr(1, 5), 32'h0);
    bus(1, adr(1, 0), 32'h8001);
    clash_ram <= 1;
    exp_wr.push_back({pb[15:0], pa[15:0] ^ 16'h3c3c});
    bus(1, adr(1, 1), 32'h8005);
    wait_done(0);
    clash_ram <= 0;
    rd(adr(1, 1), 16'h0005);
    rd(`OFF_CH_STATUS, 16'h0100);
    rd(`OFF_COLLISION, 16'h0002);
    rd(`OFF_LAST_ADDR, pb[15:0]);
    bus(1, `OFF_COLLISION, 32'h2);
    rd(`OFF_COLLISION, 16'h0);
    // Channel 2: two requests on line 42, noise on unselected lines.
    bus(1, adr(2, 2), pb);
    bus(1, adr(2, 4), pa);
    bus(1, adr(2, 5), 32'h1);
    bus(1, adr(2, 1), 32'h2a);
    bus(1, adr(2, 0), 32'h8000);
    lines <= {$urandom, $urandom, $urandom, $urandom} & ~(128'h1 << 5 | 128'h1 << 42 | 128'h1 << 127);
    exp_wr.push_back({pb[15:0], pa[15:0] ^ 16'h3c3c});
    exp_wr.push_back({pb[15:0] + 16'h2, pa[15:0] ^ 16'h3c3c});
    repeat (2) begin @(posedge hclk); lines[42] <= 1; repeat (5) @(posedge hclk); lines[42] <= 0; end
    wait_done(0);
    rd(`OFF_CH_STATUS, 16'h0200);
    // Channel 3: ram to peripheral with a peripheral clash.
    bus(1, adr(3, 0), 32'ha001);
    clash_per <= 1;
    bus(1, adr(3, 1), 32'h807f);
    wait_done(1);
    clash_per <= 0;
    rd(`OFF_COLLISION, 16'h0800);
    rd(`OFF_CH_STATUS, 16'h0300);
    // Channel 0: continuous ping-pong alternates the two bases.
    bus(1, adr(0, 2), pb);
    bus(1, adr(0, 3), pa);
    bus(1, adr(0, 4), pa);
    bus(1, adr(0, 5), 32'h0);
    bus(1, adr(0, 0), 32'h8002);
    for (int k = 0; k < 2; k++)
    begin
      exp_wr.push_back({k ? pa[15:0] : pb[15:0], pa[15:0] ^ 16'h3c3c});
      bus(1, adr(0, 1), 32'h807f);
      wait_done(0);
      rd(`OFF_CH_STATUS, k ? 16'h0000 : 16'h0001);
    end
    // Channels 0 to 2 each ended a block; channel 3 never reached its count.
    chk("block events", 32'h7, {28'h0, ev});
    finish_test();
  end
endmodule // dma_channels_tb_top

// >>> testbench/dma_far_side.sv
// Model of the peripheral bus and the DMA RAM port facing the channel block.
module dma_far_side
(
  input wire hclk,
  input wire [15:0] ram_addr_q,
  input wire ram_rd_q,
  input wire ram_wr_q,
  input wire [15:0] per_addr_q,
  input wire per_rd_q,
  input wire per_wr_q,
  input wire clash_ram,
  input wire clash_per,
  output logic [15:0] ram_rdata,
  output logic [15:0] per_rdata,
  output logic ram_wr_clash,
  output logic per_wr_clash
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------------------
  // Read data follows the address; outside a read it shows the inverse.
  // --------------------------------------------------------------------------
  // Inverting idle data keeps a late sample from matching by luck.
  assign ram_rdata = ram_rd_q ? ram_addr_q ^ 16'h3c3c : ~(ram_addr_q ^ 16'h3c3c);
  assign per_rdata = per_rd_q ? per_addr_q ^ 16'h3c3c : ~(per_addr_q ^ 16'h3c3c);
  // Clashes appear only when the bench asks and only in a write cycle.
  assign ram_wr_clash = clash_ram & ram_wr_q;
  assign per_wr_clash = clash_per & per_wr_q;
endmodule // dma_far_side
